// [inc/gmc_pkg.sv]
// Package for the GPIO ports and mode configuration block
package gmc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_CFG_ADDR     = 16'hF088; // ram_and_irq_mode_config
	localparam logic [7:0]  MODE_CFG_RESET    = 8'h00;
	localparam logic [7:0]  MODE_CFG_WR_MASK  = 8'h0F;    // Bits 7..4 reserved
	localparam int          BLOCK_BIT         = 0;        // code_ram_write_block
	localparam int          SPLIT_LSB         = 1;        // ram_split_select[1:0]
	localparam int          POLARITY_BIT      = 3;        // host_irq_polarity
	// ------------------------------------------------------------
	// RAM split encodings and code limits (byte sizes)
	// ------------------------------------------------------------
	localparam logic [1:0]  SPLIT_32K_CODE    = 2'h0;
	localparam logic [1:0]  SPLIT_16K_CODE    = 2'h1;
	localparam logic [1:0]  SPLIT_8K_CODE     = 2'h2;
	localparam logic [1:0]  SPLIT_RESERVED    = 2'h3;
	localparam logic [16:0] CODE_SIZE_32K     = 17'h08000;
	localparam logic [16:0] CODE_SIZE_16K     = 17'h04000;
	localparam logic [16:0] CODE_SIZE_8K      = 17'h02000;
	localparam logic [16:0] SHARED_RAM_BYTES  = 17'h0A000; // 40K
	// ------------------------------------------------------------
	// Port bit roles
	// ------------------------------------------------------------
	localparam logic [7:0]  P2_OPEN_DRAIN     = 8'h0E; // Port 2 bits 1..3
	localparam logic [7:0]  P2_PD_CAPABLE     = 8'h7F; // Port 2 pin 7 pullup only
	localparam logic [7:0]  P3_PD_CAPABLE     = 8'hFC; // Port 3 pins 0,1 pullup only
	localparam logic [7:0]  P3_WAKE_CAPABLE   = 8'h3C; // Port 3 bits 2..5
	localparam logic [7:0]  PORT_RESET        = 8'hFF; // Latches idle high
endpackage : gmc_pkg

// [rtl/gmc_top.sv]
// GPIO ports 2 and 3 with quasi-bidirectional drive except open drain port 2 bits 1..3, plus the mode configuration register
`timescale 1ns/1ps
module gmc_top
	import gmc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,         // Power-up or watchdog reset
	input  wire logic        clk_en,
	input  wire logic        bus_reset,       // Host bus reset, does not touch mode
	// Special function register access from the microcontroller
	input  wire logic [15:0] xaddr,
	input  wire logic        xwr,
	input  wire logic        xrd,
	input  wire logic [7:0]  xwdata,
	output logic      [7:0]  xrdata,
	// Port bit access (bit addressable)
	input  wire logic [7:0]  p2_wr_mask,
	input  wire logic [7:0]  p2_wr_data,
	input  wire logic [7:0]  p3_wr_mask,
	input  wire logic [7:0]  p3_wr_data,
	output logic      [7:0]  p2_pin_value,
	output logic      [7:0]  p3_pin_value,
	output logic      [7:0]  p2_latch,
	output logic      [7:0]  p3_latch,
	// Serial port alternate function
	input  wire logic        serial_enable,
	input  wire logic        serial_tx_data,
	output logic             serial_rx_pin,
	// Pins, split into input, output and output enable
	input  wire logic [7:0]  p2_in,
	output logic      [7:0]  p2_out,
	output logic      [7:0]  p2_oe,
	input  wire logic [7:0]  p3_in,
	output logic      [7:0]  p3_out,
	output logic      [7:0]  p3_oe,
	output logic      [3:0]  wake_pins,
	// Code RAM write gating
	input  wire logic        code_wr_req,
	input  wire logic [15:0] code_wr_addr,
	output logic             code_wr_en,
	output logic      [16:0] code_size,
	output logic      [16:0] fifo_size,
	// Host interrupt pin
	input  wire logic        host_irq_req,
	output logic             host_irq_pin
);
	import gmc_pkg::*;

	// ------------------------------------------------------------
	// Mode configuration register
	// ------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] mode_next;

	// Only writable bits stored; bus reset has no effect
	always_comb begin
		mode_next = mode_reg;
		if (xwr && xaddr == MODE_CFG_ADDR) begin
			mode_next = xwdata & MODE_CFG_WR_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= MODE_CFG_RESET;
		end else if (clk_en) begin
			mode_reg <= mode_next;
		end
	end

	logic       write_block;
	logic [1:0] split_sel;
	logic       irq_low;
	assign write_block = mode_reg[BLOCK_BIT];
	assign split_sel   = mode_reg[SPLIT_LSB +: 2];
	assign irq_low     = mode_reg[POLARITY_BIT];

	// ------------------------------------------------------------
	// Port latches and quasi-bidirectional drive
	// ------------------------------------------------------------
	logic [7:0] p2_reg, p2_next, p3_reg, p3_next;
	logic [7:0] p2_prev_reg, p3_prev_reg;
	logic [7:0] p2_out_reg, p2_oe_reg, p3_out_reg, p3_oe_reg;
	logic [7:0] p2_oe_next, p3_oe_next, p3_drv, p3_out_next;
	logic [7:0] p2_pin_reg, p3_pin_reg;
	logic       rx_reg;

	// Masked bit writes keep other bits untouched
	always_comb begin
		p2_next = (p2_reg & ~p2_wr_mask) | (p2_wr_data & p2_wr_mask);
		p3_next = (p3_reg & ~p3_wr_mask) | (p3_wr_data & p3_wr_mask);
		p3_drv  = p3_next;
		if (serial_enable) begin
			p3_drv[1] = serial_tx_data;
		end
	end

	// Drive enables per bit: low always driven, rising edge driven once except on port 2 open drain bits
	for (genvar i = 0; i < 8; i++) begin : g_bit
		always_comb begin
			if (P2_OPEN_DRAIN[i]) begin
				p2_oe_next[i] = ~p2_next[i];
			end else begin
				p2_oe_next[i] = ~p2_next[i] | (p2_next[i] & ~p2_prev_reg[i]);
			end
			p3_oe_next[i]  = ~p3_drv[i] | (p3_drv[i] & ~p3_prev_reg[i]);
			p3_out_next[i] = p3_drv[i];
		end
	end

	// Register all pin drive and sampled inputs
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			p2_reg      <= PORT_RESET;
			p3_reg      <= PORT_RESET;
			p2_prev_reg <= PORT_RESET;
			p3_prev_reg <= PORT_RESET;
			p2_out_reg  <= PORT_RESET;
			p3_out_reg  <= PORT_RESET;
			p2_oe_reg   <= 8'h00;
			p3_oe_reg   <= 8'h00;
			p2_pin_reg  <= PORT_RESET;
			p3_pin_reg  <= PORT_RESET;
			rx_reg      <= 1'b1;
		end else if (clk_en) begin
			p2_reg      <= p2_next;
			p3_reg      <= p3_next;
			p2_prev_reg <= p2_next;
			p3_prev_reg <= p3_drv;
			p2_out_reg  <= p2_next;
			p3_out_reg  <= p3_out_next;
			p2_oe_reg   <= p2_oe_next;
			p3_oe_reg   <= p3_oe_next;
			p2_pin_reg  <= p2_in;
			p3_pin_reg  <= p3_in;
			rx_reg      <= p3_in[0];
		end
	end

	// ------------------------------------------------------------
	// Code RAM gating, partition and interrupt polarity
	// ------------------------------------------------------------
	logic [16:0] code_lim;
	logic        wr_en_reg, irq_reg;
	logic [16:0] code_size_reg, fifo_size_reg;
	logic [7:0]  rdata_reg;

	// Partition select; reserved code keeps the default split
	always_comb begin
		case (split_sel)
			SPLIT_16K_CODE: code_lim = CODE_SIZE_16K;
			SPLIT_8K_CODE:  code_lim = CODE_SIZE_8K;
			default:        code_lim = CODE_SIZE_32K;
		endcase
	end

	// Gate writes, size outputs, polarity and readback
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_en_reg     <= 1'b0;
			irq_reg       <= 1'b0;
			code_size_reg <= CODE_SIZE_32K;
			fifo_size_reg <= SHARED_RAM_BYTES - CODE_SIZE_32K;
			rdata_reg     <= 8'h00;
		end else if (clk_en) begin
			wr_en_reg     <= code_wr_req && !write_block && ({1'b0, code_wr_addr} < code_lim);
			irq_reg       <= host_irq_req ^ irq_low;
			code_size_reg <= code_lim;
			fifo_size_reg <= SHARED_RAM_BYTES - code_lim;
			rdata_reg     <= (xrd && xaddr == MODE_CFG_ADDR) ? mode_reg : 8'h00;
		end
	end

	assign xrdata        = rdata_reg;
	assign p2_pin_value  = p2_pin_reg;
	assign p3_pin_value  = p3_pin_reg;
	assign p2_latch      = p2_reg;
	assign p3_latch      = p3_reg;
	assign serial_rx_pin = rx_reg;
	assign p2_out        = p2_out_reg;
	assign p2_oe         = p2_oe_reg;
	assign p3_out        = p3_out_reg;
	assign p3_oe         = p3_oe_reg;
	assign wake_pins     = p3_pin_reg[5:2];
	assign code_wr_en    = wr_en_reg;
	assign code_size     = code_size_reg;
	assign fifo_size     = fifo_size_reg;
	assign host_irq_pin  = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_mode_rsv;
		@(posedge ref_clk) disable iff (!reset_n) mode_reg[7:4] == 4'h0;
	endproperty
	a_mode_rsv: assert property (p_mode_rsv) else $error("reserved mode bits set");

	property p_bus_reset_keeps;
		@(posedge ref_clk) disable iff (!reset_n) (bus_reset && !xwr && clk_en) |=> $stable(mode_reg);
	endproperty
	a_bus_reset_keeps: assert property (p_bus_reset_keeps) else $error("bus reset changed mode");

	property p_block;
		@(posedge ref_clk) disable iff (!reset_n) (clk_en && write_block && code_wr_req) |=> !code_wr_en;
	endproperty
	a_block: assert property (p_block) else $error("blocked write passed");

	property p_code_max;
		@(posedge ref_clk) disable iff (!reset_n) code_size <= CODE_SIZE_32K && code_size + fifo_size == SHARED_RAM_BYTES;
	endproperty
	a_code_max: assert property (p_code_max) else $error("code size out of range");

	property p_split;
		@(posedge ref_clk) disable iff (!reset_n) (clk_en && split_sel == SPLIT_8K_CODE) |=> code_size == CODE_SIZE_8K;
	endproperty
	a_split: assert property (p_split) else $error("split mismatch");

	property p_polarity;
		@(posedge ref_clk) disable iff (!reset_n) clk_en |=> host_irq_pin == ($past(host_irq_req) ^ $past(irq_low));
	endproperty
	a_polarity: assert property (p_polarity) else $error("irq polarity wrong");

	property p_high_pulse;
		@(posedge ref_clk) disable iff (!reset_n)
			(clk_en && p2_next[0] && !p2_prev_reg[0]) |=> p2_oe[0] && p2_out[0];
	endproperty
	a_high_pulse: assert property (p_high_pulse) else $error("rising drive missing");

	property p_float;
		@(posedge ref_clk) disable iff (!reset_n)
			(clk_en && p2_next[0] && p2_prev_reg[0]) |=> !p2_oe[0];
	endproperty
	a_float: assert property (p_float) else $error("high not released");

	property p_open_drain;
		@(posedge ref_clk) disable iff (!reset_n) (p2_oe & p2_out & P2_OPEN_DRAIN) == 8'h00;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

	c_block: cover property (@(posedge ref_clk) disable iff (!reset_n) write_block && code_wr_req);
	c_split16: cover property (@(posedge ref_clk) disable iff (!reset_n) split_sel == SPLIT_16K_CODE);
	c_irq_low: cover property (@(posedge ref_clk) disable iff (!reset_n) irq_low && host_irq_req);
	c_rise: cover property (@(posedge ref_clk) disable iff (!reset_n) p3_oe[4] && p3_out[4]);
endmodule : gmc_top

// [verif/gmc_mcu_model.sv]
// Microcontroller side model: port bit writes and board pins, with pullups on port 2 only
`timescale 1ns/1ps
module gmc_mcu_model (
	input  wire logic       go,
	input  wire logic       sel3,
	input  wire logic [7:0] mask,
	input  wire logic [7:0] data,
	input  wire logic [7:0] p2_out,
	input  wire logic [7:0] p2_oe,
	input  wire logic [7:0] p3_out,
	input  wire logic [7:0] p3_oe,
	input  wire logic [7:0] p3_ext,
	output logic      [7:0] p2_wr_mask,
	output logic      [7:0] p2_wr_data,
	output logic      [7:0] p3_wr_mask,
	output logic      [7:0] p3_wr_data,
	output logic      [7:0] p2_in,
	output logic      [7:0] p3_in
);
	// Bit writes to one port, unmasked bits left alone
	assign p2_wr_mask = (go && !sel3) ? mask : 8'h00;
	assign p3_wr_mask = (go && sel3) ? mask : 8'h00;
	assign p2_wr_data = data;
	assign p3_wr_data = data;
	// Released port 2 pins rest on the pullup; released port 3 pins take the board level
	assign p2_in = (p2_oe & p2_out) | ~p2_oe;
	assign p3_in = (p3_oe & p3_out) | (~p3_oe & p3_ext);
endmodule : gmc_mcu_model

// [verif/gmc_top_test.sv]
// Self-checking testbench for the GPIO ports and mode configuration block
`timescale 1ns/1ps
module gmc_top_test;
	import gmc_pkg::*;
	logic        ref_clk, reset_n, bus_reset, xwr, xrd, go, sel3, code_wr_req, host_irq_req;
	logic        serial_rx_pin, code_wr_en, host_irq_pin;
	logic        clk_en, ser_en, ser_tx;
	logic        rd_d = 1'b0;
	logic [15:0] xaddr, code_wr_addr;
	logic [7:0]  xwdata, xrdata, mask, data, p3_ext, lfsr_reg, exp_pins;
	logic [7:0]  p2_wr_mask, p2_wr_data, p3_wr_mask, p3_wr_data, p2_in, p3_in;
	logic [7:0]  p2_out, p2_oe, p3_out, p3_oe, p2_latch, p3_latch, p2_pin_value, p3_pin_value;
	logic [3:0]  wake_pins;
	logic [16:0] code_size, fifo_size;
	logic [7:0]  rd_q[$];
	int          n_errors = 0, compares = 0, cycles = 0;
	// Design and microcontroller side model
	gmc_top DUT (.ref_clk, .reset_n, .clk_en, .bus_reset, .xaddr, .xwr, .xrd, .xwdata, .xrdata,
		.p2_wr_mask, .p2_wr_data, .p3_wr_mask, .p3_wr_data, .p2_pin_value, .p3_pin_value, .p2_latch,
		.p3_latch, .serial_enable(ser_en), .serial_tx_data(ser_tx), .serial_rx_pin, .p2_in, .p2_out, .p2_oe,
		.p3_in, .p3_out, .p3_oe, .wake_pins, .code_wr_req, .code_wr_addr, .code_wr_en, .code_size,
		.fifo_size, .host_irq_req, .host_irq_pin);
	gmc_mcu_model mcu (.go, .sel3, .mask, .data, .p2_out, .p2_oe, .p3_out, .p3_oe, .p3_ext, .p2_wr_mask,
		.p2_wr_data, .p3_wr_mask, .p3_wr_data, .p2_in, .p3_in);
	// Clock at 100 MHz
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] lfsr_step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_step
	task automatic tally_and_finish();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Register accesses: request held until the taking edge
	task automatic reg_wr(input logic [7:0] d);
		@(posedge ref_clk);
		xwr <= 1'b1;
		xaddr <= MODE_CFG_ADDR;
		xwdata <= d;
		@(posedge ref_clk);
		xwr <= 1'b0;
		xwdata <= ~d;
	endtask : reg_wr
	task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		xrd <= 1'b1;
		xaddr <= a;
		rd_q.push_back(exp);
		@(posedge ref_clk);
		xrd <= 1'b0;
	endtask : reg_rd
	task automatic mode_chk(input logic [7:0] w, input logic [16:0] cs);
		reg_wr(w);
		repeat (2) @(negedge ref_clk);
		check("code_size", code_size, cs);
		check("fifo_size", fifo_size, SHARED_RAM_BYTES - cs);
		reg_rd(MODE_CFG_ADDR, w & 8'h0F);
	endtask : mode_chk
	task automatic port_wr(input logic s, input logic [7:0] m, input logic [7:0] d);
		@(posedge ref_clk);
		go <= 1'b1;
		sel3 <= s;
		mask <= m;
		data <= d;
		@(posedge ref_clk);
		go <= 1'b0;
		@(negedge ref_clk);
	endtask : port_wr
	task automatic code_try(input logic [15:0] a, input logic e);
		repeat (2) @(posedge ref_clk);
		code_wr_req <= 1'b1;
		code_wr_addr <= a;
		@(posedge ref_clk);
		code_wr_req <= 1'b0;
		@(negedge ref_clk);
		check("code_wr_en", {16'h0, code_wr_en}, {16'h0, e});
	endtask : code_try
	// Read data watcher against the queue of noted results, plus hang limit
	always @(posedge ref_clk) begin
		if (rd_d)
			check("xrdata", {9'h0, xrdata}, {9'h0, rd_q.pop_front()});
		rd_d <= xrd;
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		{reset_n, bus_reset, xwr, xrd, go, sel3, code_wr_req, host_irq_req} = 8'h00;
		{xaddr, code_wr_addr, xwdata, mask, data} = 56'h0;
		{clk_en, ser_en, ser_tx} = 3'b100;
		p3_ext = 8'hFF;
		lfsr_reg = 8'h4C;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(negedge ref_clk);
		check("code_size", code_size, CODE_SIZE_32K);
		reg_rd(MODE_CFG_ADDR, MODE_CFG_RESET);
		reg_rd(16'hF089, 8'h00);
		mode_chk(8'hFF, CODE_SIZE_32K);
		mode_chk(8'h02, CODE_SIZE_16K);
		mode_chk(8'h04, CODE_SIZE_8K);
		mode_chk(8'h00, CODE_SIZE_32K);
		reg_wr(8'h0B);
		bus_reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		bus_reset <= 1'b0;
		// Frozen clock enable must swallow this write
		clk_en <= 1'b0;
		reg_wr(8'h06);
		clk_en <= 1'b1;
		reg_rd(MODE_CFG_ADDR, 8'h0B);
		code_try(16'h0010, 1'b0);
		reg_wr(8'h02);
		code_try(16'h3FFF, 1'b1);
		code_try(16'h4000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			reg_wr({4'h0, i[1], 3'h0});
			@(posedge ref_clk);
			host_irq_req <= i[0];
			@(posedge ref_clk);
			@(negedge ref_clk);
			check("host_irq_pin", {16'h0, host_irq_pin}, {16'h0, i[0] ^ i[1]});
		end
		port_wr(1'b0, 8'h0F, 8'h00);
		check("p2_drive_low", {p2_oe[3:0], p2_out[3:0]}, 8'hF0);
		port_wr(1'b0, 8'h0F, 8'h0F);
		check("p2_drive_high", {p2_oe[0], p2_out[0]}, 2'b11);
		check("p2_open_drain", p2_oe & p2_out & P2_OPEN_DRAIN, 8'h00);
		check("p2_pin_value", p2_pin_value, 8'hF0);
		@(negedge ref_clk);
		check("p2_float", {p2_oe[3:0], p2_latch[3:0]}, 8'h0F);
		check("p2_pin_value", p2_pin_value, 8'hFF);
		lfsr_reg = lfsr_step(lfsr_reg);
		@(posedge ref_clk);
		p3_ext <= lfsr_reg;
		lfsr_reg = lfsr_step(lfsr_reg);
		port_wr(1'b1, 8'h0F, lfsr_reg);
		exp_pins = p3_ext & {4'hF, lfsr_reg[3:0]};
		check("p3_latch", p3_latch, {4'hF, lfsr_reg[3:0]});
		repeat (2) @(negedge ref_clk);
		check("p3_pin_value", p3_pin_value, exp_pins);
		check("wake_pins", wake_pins, exp_pins[5:2]);
		check("serial_rx_pin", serial_rx_pin, exp_pins[0]);
		// Serial transmit takes over port 3 bit 1, opposite to its latch
		@(posedge ref_clk);
		ser_en <= 1'b1;
		ser_tx <= ~lfsr_reg[1];
		@(posedge ref_clk);
		@(negedge ref_clk);
		check("p3_tx_drive", {p3_oe[1], p3_out[1]}, {1'b1, ~lfsr_reg[1]});
		repeat (3) @(posedge ref_clk);
		tally_and_finish();
	end
endmodule : gmc_top_test
